// file: hw/seb_pkg.sv
// Shared constants, states and carrier types of the serial EEPROM bus slave
package seb_pkg;

   // ==========================================================
   // Array geometry and word layout
   localparam int SEB_ADDR_W = 12;
   localparam int SEB_DEPTH = 4096;
   localparam int SEB_WORD_W = 8;
   localparam int SEB_TYPE_MSB = 7;
   localparam int SEB_TYPE_LSB = 4;
   localparam int SEB_SEL_MSB = 3;
   localparam int SEB_SEL_LSB = 1;
   localparam int SEB_RW_BIT = 0;
   localparam int SEB_ADDR_HI_W = 4;

   // ==========================================================
   // Bit counter marks within one nine-clock word
   localparam logic [3:0] SEB_CNT_LAST = 4'h8;
   localparam logic [3:0] SEB_CNT_NINTH = 4'h9;

   // ==========================================================
   // Timing
   localparam int SEB_CLK_MHZ = 100;
   localparam int SEB_SCL_MAX_KHZ = 400;
   localparam int SEB_PROGRAM_CYCLE_TIME_MS = 5;
   // Longest time; at 100 MHz the count is exact, with no rounding
   localparam int SEB_PROGRAM_CYCLES = SEB_PROGRAM_CYCLE_TIME_MS * 1000 * SEB_CLK_MHZ;
   localparam int SEB_PROG_CNT_W = 20;

   // ==========================================================
   // Protocol states
   typedef enum logic [3:0] {
      SEB_IDLE = 4'h0,
      SEB_SELECT = 4'h1,
      SEB_ADDR_HI = 4'h2,
      SEB_ADDR_LO = 4'h3,
      SEB_DATA = 4'h4,
      SEB_READ = 4'h5,
      SEB_HOLD = 4'h6,
      SEB_PROGRAM = 4'h7
   } seb_state_t;

   // ==========================================================
   // Sampled bus pins travel together
   typedef struct packed {
      logic scl;
      logic sda;
   } seb_pins_t;

   localparam seb_pins_t SEB_PINS_IDLE = 2'h3;

endpackage : seb_pkg

// file: hw/seb_serial_eeprom_bus_slave.sv
// Two-wire bus slave front end with its 4096-byte array and programming timer
`timescale 1ns/1ns
module seb_serial_eeprom_bus_slave
   import seb_pkg::*;
#(
   // Arbitrary value, not the part's real type code
   parameter logic [3:0] TYPE_CODE = 4'h5,
   parameter int PROG_CYCLES = SEB_PROGRAM_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic SCL,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic SELECT_PIN_0,
   input wire logic SELECT_PIN_1,
   input wire logic SELECT_PIN_2,
   input wire logic WRITE_PROTECT,
   output logic BUSY
);

   // ==========================================================
   // Pin synchronisers
   seb_pins_t pin1_q, pin2_q, pin3_q;
   logic [3:0] aux1_q, aux2_q;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   logic [2:0] sel_pins;
   logic wp_s;

   // Two flops per pin; third stage only for edge finding
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         pin1_q <= SEB_PINS_IDLE;
         pin2_q <= SEB_PINS_IDLE;
         pin3_q <= SEB_PINS_IDLE;
         aux1_q <= 4'h0;
         aux2_q <= 4'h0;
      end else begin
         pin1_q <= '{scl: SCL, sda: SDA_I};
         pin2_q <= pin1_q;
         pin3_q <= pin2_q;
         aux1_q <= {WRITE_PROTECT, SELECT_PIN_2, SELECT_PIN_1, SELECT_PIN_0};
         aux2_q <= aux1_q;
      end
   end

   // Edges and bus conditions from the second and third stages
   assign scl_rise = pin2_q.scl & ~pin3_q.scl;
   assign scl_fall = ~pin2_q.scl & pin3_q.scl;
   assign start_cond = pin2_q.scl & pin3_q.scl & pin3_q.sda & ~pin2_q.sda;
   assign stop_cond = pin2_q.scl & pin3_q.scl & ~pin3_q.sda & pin2_q.sda;
   // Floating pins rely on the pad pull-down, so they read low
   assign sel_pins = aux2_q[2:0];
   assign wp_s = aux2_q[3];

   // ==========================================================
   // Select word decode
   function automatic logic sel_match(input logic [7:0] word, input logic [2:0] pins);
      sel_match = (word[SEB_TYPE_MSB:SEB_TYPE_LSB] == TYPE_CODE) &&
                  (word[SEB_SEL_MSB:SEB_SEL_LSB] == pins);
   endfunction : sel_match

   // ==========================================================
   // Protocol engine state
   seb_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic [SEB_ADDR_W-1:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic pend_q, pend_d;
   logic rw_q, rw_d;
   logic oe_q, oe_d;
   logic mack_q, mack_d;
   logic [SEB_PROG_CNT_W-1:0] prog_q, prog_d;
   logic mem_we;
   logic [7:0] mem [SEB_DEPTH];
   logic [7:0] rd_word;

   assign rd_word = mem[addr_q];

   // Next-state logic for the whole slave
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      pend_d = pend_q;
      rw_d = rw_q;
      oe_d = oe_q;
      mack_d = mack_q;
      prog_d = prog_q;
      mem_we = 1'b0;
      if (st_q == SEB_PROGRAM) begin
         // Bus pins are not looked at while the array is busy
         oe_d = 1'b0;
         prog_d = prog_q + 1'b1;
         if (prog_q == SEB_PROG_CNT_W'(PROG_CYCLES - 1)) begin
            mem_we = 1'b1;
            addr_d = addr_q + 1'b1;
            prog_d = '0;
            st_d = SEB_IDLE;
         end
      end else if (start_cond) begin
         // A repeated start abandons any unfinished write
         st_d = SEB_SELECT;
         cnt_d = 4'h0;
         oe_d = 1'b0;
         pend_d = 1'b0;
      end else if (stop_cond) begin
         oe_d = 1'b0;
         cnt_d = 4'h0;
         pend_d = 1'b0;
         st_d = pend_q ? SEB_PROGRAM : SEB_IDLE;
      end else begin
         case (st_q)
            SEB_SELECT, SEB_ADDR_HI, SEB_ADDR_LO, SEB_DATA: begin
               if (scl_rise) begin
                  if (cnt_q < SEB_CNT_LAST) begin
                     sh_d = {sh_q[6:0], pin2_q.sda};
                     cnt_d = cnt_q + 4'h1;
                  end else if (cnt_q == SEB_CNT_LAST) begin
                     cnt_d = SEB_CNT_NINTH;
                  end
               end
               if (scl_fall && cnt_q == SEB_CNT_LAST) begin
                  case (st_q)
                     SEB_SELECT: begin
                        if (sel_match(sh_q, sel_pins)) begin
                           oe_d = 1'b1;
                           rw_d = sh_q[SEB_RW_BIT];
                        end else begin
                           st_d = SEB_IDLE;
                           cnt_d = 4'h0;
                        end
                     end
                     SEB_ADDR_HI: begin
                        oe_d = 1'b1;
                        addr_d[SEB_ADDR_W-1:SEB_WORD_W] = sh_q[SEB_ADDR_HI_W-1:0];
                     end
                     SEB_ADDR_LO: begin
                        oe_d = 1'b1;
                        addr_d[SEB_WORD_W-1:0] = sh_q;
                     end
                     default: begin
                        // Protected data byte gets no-ack and no write
                        if (!wp_s) begin
                           oe_d = 1'b1;
                           wdata_d = sh_q;
                           pend_d = 1'b1;
                        end
                     end
                  endcase
               end
               if (scl_fall && cnt_q == SEB_CNT_NINTH) begin
                  oe_d = 1'b0;
                  cnt_d = 4'h0;
                  case (st_q)
                     SEB_SELECT: begin
                        if (rw_q) begin
                           st_d = SEB_READ;
                           sh_d = rd_word;
                           oe_d = ~rd_word[7];
                        end else begin
                           st_d = SEB_ADDR_HI;
                        end
                     end
                     SEB_ADDR_HI: st_d = SEB_ADDR_LO;
                     SEB_ADDR_LO: st_d = SEB_DATA;
                     default: st_d = SEB_HOLD; // Only byte write is kept
                  endcase
               end
            end
            SEB_READ: begin
               if (scl_rise) begin
                  if (cnt_q < SEB_CNT_LAST) begin
                     cnt_d = cnt_q + 4'h1;
                  end else if (cnt_q == SEB_CNT_LAST) begin
                     mack_d = pin2_q.sda;
                     cnt_d = SEB_CNT_NINTH;
                  end
               end
               if (scl_fall) begin
                  if (cnt_q >= 4'h1 && cnt_q < SEB_CNT_LAST) begin
                     oe_d = ~sh_q[6];
                     sh_d = {sh_q[6:0], 1'b0};
                  end else if (cnt_q == SEB_CNT_LAST) begin
                     oe_d = 1'b0;
                     addr_d = addr_q + 1'b1;
                  end else if (cnt_q == SEB_CNT_NINTH) begin
                     cnt_d = 4'h0;
                     if (!mack_q) begin
                        sh_d = rd_word;
                        oe_d = ~rd_word[7];
                     end else begin
                        st_d = SEB_HOLD;
                     end
                  end
               end
            end
            SEB_HOLD, SEB_IDLE: begin
               // Released; waits for start or stop
               oe_d = 1'b0;
            end
            default: begin
               st_d = SEB_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   // Registers of the protocol engine
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= SEB_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         addr_q <= '0;
         wdata_q <= 8'h00;
         pend_q <= 1'b0;
         rw_q <= 1'b0;
         oe_q <= 1'b0;
         mack_q <= 1'b1;
         prog_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         pend_q <= pend_d;
         rw_q <= rw_d;
         oe_q <= oe_d;
         mack_q <= mack_d;
         prog_q <= prog_d;
      end
   end

   // Array write at the end of programming; no reset, contents persist
   always_ff @(posedge REF_CLK) begin
      if (mem_we) begin
         mem[addr_q] <= wdata_q;
      end
   end

   // ==========================================================
   // Pin outputs
   assign SDA_O = 1'b0;
   assign SDA_OE = oe_q;
   assign BUSY = (st_q == SEB_PROGRAM);

   // ==========================================================
   // Checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   a_drive_after_fall:
   assert property ($rose(oe_q) |-> $past(scl_fall)) else $error("drive began off a fall");

   a_open_drain_low:
   assert property (SDA_O == 1'b0) else $error("data line driven high");

   a_select_mismatch:
   assert property (st_q == SEB_SELECT && scl_fall && cnt_q == SEB_CNT_LAST &&
                    !start_cond && !stop_cond && !sel_match(sh_q, sel_pins)
                    |=> st_q == SEB_IDLE && !oe_q) else $error("mismatch was answered");

   a_protect_nack:
   assert property (st_q == SEB_DATA && scl_fall && cnt_q == SEB_CNT_LAST && wp_s &&
                    !start_cond && !stop_cond |=> (!oe_q && !pend_q) [*2])
      else $error("protected byte acked");

   a_data_ack:
   assert property (st_q == SEB_DATA && scl_fall && cnt_q == SEB_CNT_LAST && !wp_s &&
                    !start_cond && !stop_cond |=> oe_q && pend_q) else $error("data not acked");

   a_address_ack:
   assert property ((st_q == SEB_ADDR_HI || st_q == SEB_ADDR_LO) && scl_fall &&
                    cnt_q == SEB_CNT_LAST && !start_cond && !stop_cond |=> oe_q)
      else $error("address not acked");

   a_start_seen:
   assert property (start_cond && st_q != SEB_PROGRAM |=> st_q == SEB_SELECT && cnt_q == 4'h0)
      else $error("start missed");

   a_stop_program:
   assert property (stop_cond && !start_cond && pend_q && st_q != SEB_PROGRAM
                    |=> BUSY && prog_q == '0) else $error("program cycle not begun");

   a_program_ends:
   assert property (st_q == SEB_PROGRAM && prog_q == SEB_PROG_CNT_W'(PROG_CYCLES - 1)
                    |=> st_q == SEB_IDLE && !BUSY) else $error("program cycle overran");

   a_program_deaf:
   assert property (BUSY |-> !oe_q ##1 (BUSY || st_q == SEB_IDLE))
      else $error("bus acted on while busy");

   a_read_release:
   assert property (st_q == SEB_READ && scl_fall && cnt_q == SEB_CNT_LAST &&
                    !start_cond && !stop_cond |=> !oe_q) else $error("no release after byte");

   a_read_noack_hold:
   assert property (st_q == SEB_READ && scl_fall && cnt_q == SEB_CNT_NINTH && mack_q &&
                    !start_cond && !stop_cond |=> st_q == SEB_HOLD && !oe_q)
      else $error("read went on after no-ack");

   // Three cycles of drive must reach the synchroniser as a low level
   a_pad_reads_low:
   assert property (oe_q && $past(oe_q) && $past(oe_q, 2) |-> !pin2_q.sda)
      else $error("driven data line not low");

   a_busy_ignores_start:
   assert property (st_q == SEB_PROGRAM && start_cond |=> st_q != SEB_SELECT && !oe_q)
      else $error("start taken while busy");

   a_select_match_ack:
   assert property (st_q == SEB_SELECT && scl_fall && cnt_q == SEB_CNT_LAST &&
                    !start_cond && !stop_cond && sel_match(sh_q, sel_pins)
                    |=> oe_q && st_q == SEB_SELECT) else $error("match not acked");

endmodule : seb_serial_eeprom_bus_slave

// file: tb/seb_bus_master.sv
// Behavioural two-wire bus master that clocks the slave
`timescale 1ns/1ns
module seb_bus_master (
   output logic scl,
   output logic pull,
   input wire logic sda
);
   // Extra low time lets a scenario play a slow master
   int extra = 0;

   // ==========================================================
   // Idle bus: clock stands high, data released to the pull-up
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end

   // One clock: data set in the low phase, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      // Offsets kept on multiples of five so no change meets a system clock edge
      pull = ~b;
      #(40 + extra);
      scl = 1'b1;
      #30 r = sda;
      #35 scl = 1'b0;
      #20;
   endtask : bit_io

   // Data falls while the clock is high; also serves as repeated start
   task automatic start();
      pull = 1'b0;
      #40 scl = 1'b1;
      #60 pull = 1'b1;
      #60 scl = 1'b0;
      #20;
   endtask : start

   // Data rises while the clock is high, then bus free time
   task automatic stop();
      pull = 1'b1;
      #40 scl = 1'b1;
      #60 pull = 1'b0;
      #250;
   endtask : stop

   // Eight bits MSB first, then the ninth clock
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                       output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(ack_in, ack_out);
   endtask : xfer
endmodule : seb_bus_master

// file: tb/testbench.sv
// Self-checking bench for the serial EEPROM bus slave
`timescale 1ns/1ns
module testbench;
   import seb_pkg::*;
   // Short programming count keeps the run brief
   localparam int PROG = 200;
   // Arbitrary type code, matches the design default
   localparam logic [3:0] TC = 4'h5;
   logic ref_clk, reset, scl, m_pull, sda, sda_o, sda_oe, wp, busy;
   logic [2:0] pins;
   int errors = 0;
   int n_compared = 0;
   int busy_n = 0;

   // Open-drain wire with pull-up; the slave's level counts only while enabled
   assign sda = (sda_oe ? sda_o : 1'b1) & ~m_pull;

   seb_serial_eeprom_bus_slave #(.TYPE_CODE(TC), .PROG_CYCLES(PROG)) DUT (
      .REF_CLK(ref_clk), .RESET(reset), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE(sda_oe), .SELECT_PIN_0(pins[0]), .SELECT_PIN_1(pins[1]),
      .SELECT_PIN_2(pins[2]), .WRITE_PROTECT(wp), .BUSY(busy));
   seb_bus_master m (.scl(scl), .pull(m_pull), .sda(sda));

   // ==========================================================
   // Helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic give_verdict();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   // Strap pins change just after an edge
   task automatic drive(input logic w, input logic [2:0] p);
      @(posedge ref_clk);
      #1 wp = w;
      pins = p;
   endtask : drive

   // Send a byte, judge the slave's ninth-clock answer
   task automatic wb(input logic [7:0] d, input logic exp);
      logic [7:0] r;
      logic a;
      m.xfer(d, 1'b1, r, a);
      chk("ack", {7'h00, exp}, {7'h00, a});
   endtask : wb

   // Clock a byte out of the slave and answer it
   task automatic rb(input logic ack_in, input logic [7:0] exp);
      logic [7:0] r;
      logic a;
      m.xfer(8'hFF, ack_in, r, a);
      chk("read", exp, r);
   endtask : rb

   // Dummy write; junk in the upper nibble must be ignored
   task automatic addr(input logic [11:0] ad);
      m.start();
      wb({TC, pins, 1'b0}, 1'b0);
      wb({4'hF, ad[11:8]}, 1'b0);
      wb(ad[7:0], 1'b0);
   endtask : addr

   // ==========================================================
   // Scenarios
   task automatic t_select();
      for (int p = 2; p <= 5; p += 3) begin
         drive(1'b0, p[2:0]);
         for (int s = 0; s < 8; s++) begin
            m.start();
            wb({TC, s[2:0], 1'b0}, s != p);
            m.stop();
         end
         m.start();
         wb({TC ^ 4'h3, pins, 1'b0}, 1'b1);
         m.stop();
      end
   endtask : t_select

   // Byte write; a select sent while programming is ignored
   task automatic t_write(input logic [11:0] ad, input logic [7:0] d);
      int n;
      addr(ad);
      wb(d, 1'b0);
      busy_n = 0;
      m.stop();
      chk("busy", 8'h01, {7'h00, busy});
      m.start();
      wb({TC, pins, 1'b0}, 1'b1);
      m.stop();
      n = 0;
      while (busy === 1'b1 && n < 1000) begin
         @(posedge ref_clk);
         n++;
      end
      #1;
      chk("busy", 8'h00, {7'h00, busy});
      chk("prog_time", 8'(PROG), busy_n[7:0]);
   endtask : t_write

   // Two-byte read with protect high and a slow master
   task automatic t_read(input logic [11:0] ad, input logic [7:0] d0, input logic [7:0] d1);
      drive(1'b1, pins);
      addr(ad);
      m.start();
      wb({TC, pins, 1'b1}, 1'b0);
      m.extra = 400;
      rb(1'b0, d0);
      rb(1'b1, d1);
      m.extra = 0;
      m.stop();
      chk("busy", 8'h00, {7'h00, busy});
   endtask : t_read

   // Protected write is refused and leaves the array alone
   task automatic t_protect(input logic [11:0] ad, input logic [7:0] old);
      drive(1'b1, pins);
      addr(ad);
      wb(8'h5A, 1'b1);
      m.stop();
      chk("busy", 8'h00, {7'h00, busy});
      addr(ad);
      m.start();
      wb({TC, pins, 1'b1}, 1'b0);
      rb(1'b1, old);
      m.stop();
   endtask : t_protect

   // No-ack without stop: line stays released
   task automatic t_hold(input logic [11:0] ad, input logic [7:0] d0);
      drive(1'b0, pins);
      addr(ad);
      m.start();
      wb({TC, pins, 1'b1}, 1'b0);
      rb(1'b1, d0);
      rb(1'b1, 8'hFF);
      m.stop();
   endtask : t_hold

   // ==========================================================
   // Clock, reset, sequence and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Busy time counted on falling edges, away from the launching edge
   always @(negedge ref_clk) begin
      if (busy === 1'b1) begin
         busy_n++;
      end
   end

   initial begin
      reset = 1'b1;
      wp = 1'b0;
      pins = 3'b000;
      repeat (20) @(posedge ref_clk);
      #1 reset = 1'b0;
      repeat (5) @(posedge ref_clk);
      t_select();
      drive(1'b0, 3'b011);
      t_write(12'h123, 8'hA5);
      t_write(12'h124, 8'h3C);
      t_read(12'h123, 8'hA5, 8'h3C);
      t_protect(12'h123, 8'hA5);
      t_hold(12'h124, 8'h3C);
      give_verdict();
   end

   // Whole sequence needs well under this span
   initial begin
      #900000;
      errors++;
      give_verdict();
   end
endmodule : testbench
